// [src/slem_pkg.sv]
/*
  Shared constants and types for the serial lane error monitor.
  Assumes one clock domain and 32-bit APB with word-aligned registers.
*/
`default_nettype none
package slem_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_LINK_PAGE   = 12'h300;
  localparam logic [11:0] IDX_HOLD_CTRL   = 12'h480;
  localparam logic [11:0] IDX_CNT_CLEAR   = 12'h481;
  localparam logic [11:0] IDX_ERR_THRESH  = 12'h482;
  localparam logic [11:0] IDX_LANE6_STAT  = 12'h496;
  localparam logic [11:0] IDX_LANE7_STAT  = 12'h497;
  localparam logic [11:0] IDX_LANE0_LINK  = 12'h4B0;

  // Field positions
  localparam int POS_TC_UEK        = 2;
  localparam int POS_TC_NIT        = 1;
  localparam int POS_TC_BDE        = 0;
  localparam int POS_LANE_ENA      = 3;
  localparam int POS_OVER_BDE      = 7;
  localparam int POS_OVER_NIT      = 6;
  localparam int POS_OVER_UEK      = 5;

  // Reset values
  localparam logic [7:0] RST_STATUS   = 8'h00;
  localparam logic [7:0] RST_THRESH   = 8'hFF;
  localparam logic [2:0] RST_HOLD     = 3'h0;
  localparam logic [7:0] RST_PAGE     = 8'h00;

  // Error counter terminal value
  localparam logic [7:0] TERMINAL_CNT = 8'hFF;

  // One decode error event per type, bit order matches the status field
  typedef struct packed {
    logic unexpected_control_char_error;
    logic code_not_in_table_error;
    logic bad_disparity_error;
  } slem_lane_err_s;

endpackage : slem_pkg
`default_nettype wire

// [src/slem_err_counter.sv]
/*
  One 8-bit decode error counter with terminal-count flag.
  Assumes event, clear and hold are synchronous to clk.
*/
`default_nettype none
module slem_err_counter (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       evt,
  input  wire logic       clr,
  input  wire logic       hold,
  // Status
  output logic [7:0]      count_q,
  output logic            tc_q
);

  logic [7:0] count_d;
  logic       at_term;
  logic       stuck;

  assign at_term = count_q == slem_pkg::TERMINAL_CNT;
  assign stuck   = hold && at_term;                                       // RULE2
  // Event in the clear cycle is counted from zero, not lost
  assign count_d = clr   ? {7'h00, evt} :
                   stuck ? count_q :
                   evt   ? 8'(count_q + 8'h01) : count_q;                 // RULE3 RULE11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= slem_pkg::RST_STATUS;
      tc_q    <= 1'b0;
    end else begin
      count_q <= count_d;
      tc_q    <= (count_d == slem_pkg::TERMINAL_CNT) || (tc_q && !clr);   // RULE1
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tc_at_term: assert property (at_term |-> tc_q)  // RULE1
    else $error("terminal count without flag");
  a_hold_term: assert property (stuck && !clr |=> at_term [*1] ##0 tc_q)  // RULE2
    else $error("held counter left terminal value");
  a_wrap_term: assert property (!hold && at_term && evt && !clr |=> count_q == 8'h00)  // RULE3
    else $error("counter did not roll over");
  a_count_step: assert property (evt && !clr && !at_term |=> count_q == $past(count_q) + 8'h01)  // RULE11
    else $error("counter did not step by one");
  a_clear_zero: assert property (clr && !evt |=> count_q == 8'h00 && !tc_q)  // RULE11
    else $error("clear left a nonzero count");

endmodule : slem_err_counter
`default_nettype wire

// [src/slem_monitor.sv]
/*
  Lane error monitor register bank: counters for every lane and link,
  paged status views and an APB slave.
  Assumes error events are single-cycle pulses synchronous to pclk.
*/
// Overview of operation
// RULE1: Terminal-count status bit sets when its counter reaches 0xFF.
// RULE2: With hold set, a counter stays at 0xFF until cleared or reset.
// RULE3: With hold clear, a counter rolls over past 0xFF and keeps counting.
// RULE4: Field bit 2 unexpected control char, bit 1 not-in-table, bit 0 disparity.
// RULE5: Lane status fields show the link chosen by the page register 0x300.
// RULE6: Bit 3 of the lane 7 status register shows lane 7 enabled.
// RULE7: Lane 0 link status bit 7: disparity count reached threshold.
// RULE8: Lane 0 link status bit 6: not-in-table count reached threshold.
// RULE9: Lane 0 link status bit 5: control char count reached threshold.
// RULE10: Threshold bit is 0 below the threshold, 1 at or above it.
// RULE11: Counters step by one per detected error, from zero after reset.
`default_nettype none
module slem_monitor #(
  parameter int NUM_LINKS = 2,
  parameter int NUM_LANES = 8,
  parameter int ADDR_W    = 13
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Lane decoders, index link*NUM_LANES+lane
  input  wire slem_pkg::slem_lane_err_s [NUM_LINKS*NUM_LANES-1:0] lane_err,
  input  wire logic [NUM_LINKS*NUM_LANES-1:0] lane_enable
);

  localparam int NCH  = NUM_LINKS * NUM_LANES;
  localparam int NCNT = NCH * 3;
  localparam int PW   = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;

  // Registers
  logic [PW-1:0] link_page_q;
  logic [2:0]    hold_at_terminal_q;
  logic [7:0]    error_threshold_q;
  logic [31:0]   prdata_q;

  // Counter array
  logic [7:0]      cnt   [NCNT];
  logic [NCNT-1:0] tc_flat;
  logic [NCNT-1:0] evt_flat;
  logic [NCNT-1:0] clr_flat;

  // Bus decode
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_cap;
  logic hit_page;
  logic hit_hold;
  logic hit_clr;
  logic hit_thr;
  logic hit_l6;
  logic hit_l7;
  logic hit_l0;
  logic addr_hit;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_page  = paddr == ADDR_W'({slem_pkg::IDX_LINK_PAGE,  2'b00});
  assign hit_hold  = paddr == ADDR_W'({slem_pkg::IDX_HOLD_CTRL,  2'b00});
  assign hit_clr   = paddr == ADDR_W'({slem_pkg::IDX_CNT_CLEAR,  2'b00});
  assign hit_thr   = paddr == ADDR_W'({slem_pkg::IDX_ERR_THRESH, 2'b00});
  assign hit_l6    = paddr == ADDR_W'({slem_pkg::IDX_LANE6_STAT, 2'b00});
  assign hit_l7    = paddr == ADDR_W'({slem_pkg::IDX_LANE7_STAT, 2'b00});
  assign hit_l0    = paddr == ADDR_W'({slem_pkg::IDX_LANE0_LINK, 2'b00});
  assign addr_hit  = hit_page | hit_hold | hit_clr | hit_thr | hit_l6 | hit_l7 | hit_l0;
  // Status registers are read-only; a write to them is an error too
  assign wr_en     = access_ph && pwrite && addr_hit;
  assign rd_cap    = setup_ph && !pwrite;

  assign pready  = 1'b1;
  assign pslverr = access_ph && (!addr_hit || (pwrite && (hit_l6 || hit_l7 || hit_l0)));
  assign prdata  = prdata_q;

  // Counter instances
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    for (genvar t = 0; t < 3; t++) begin : g_type
      assign evt_flat[c*3+t] = lane_err[c][t];
      // Clear hits every lane of the page shown
      assign clr_flat[c*3+t] = wr_en && hit_clr && pwdata[t] &&
                               (PW'(c / NUM_LANES) == link_page_q);
      slem_err_counter u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .evt     (evt_flat[c*3+t]),
        .clr     (clr_flat[c*3+t]),
        .hold    (hold_at_terminal_q[t]),
        .count_q (cnt[c*3+t]),
        .tc_q    (tc_flat[c*3+t])
      );
    end
  end

  // Paged view of the selected link
  logic [NUM_LANES*3-1:0] tc_page;
  logic [NUM_LANES-1:0]   ena_page;
  logic [7:0]             l0_uek_cnt;
  logic [7:0]             l0_nit_cnt;
  logic [7:0]             l0_bde_cnt;
  int unsigned            l0_base;

  assign tc_page  = tc_flat[link_page_q*NUM_LANES*3 +: NUM_LANES*3];         // RULE5
  assign ena_page = lane_enable[link_page_q*NUM_LANES +: NUM_LANES];         // RULE5
  assign l0_base  = 32'(link_page_q) * NUM_LANES * 3;
  assign l0_uek_cnt = cnt[l0_base + slem_pkg::POS_TC_UEK];
  assign l0_nit_cnt = cnt[l0_base + slem_pkg::POS_TC_NIT];
  assign l0_bde_cnt = cnt[l0_base + slem_pkg::POS_TC_BDE];

  // Register views
  logic [7:0] lane6_view;
  logic [7:0] lane7_view;
  logic [7:0] lane0_link_report;
  logic [2:0] lane6_terminal_reached;
  logic [2:0] lane7_terminal_reached;
  logic       lane7_enabled;
  logic       lane6_enabled;
  logic       lane0_disparity_over_limit;
  logic       lane0_invalid_code_over_limit;
  logic       lane0_control_char_over_limit;

  // Field bits follow the struct order: control char, table, disparity
  assign lane6_terminal_reached = tc_page[6*3 +: 3];                          // RULE4
  assign lane7_terminal_reached = tc_page[7*3 +: 3];                          // RULE4
  assign lane6_enabled = ena_page[6];
  assign lane7_enabled = ena_page[7];                                         // RULE6

  assign lane6_view = {4'h0, lane6_enabled, lane6_terminal_reached};
  assign lane7_view = {4'h0, lane7_enabled, lane7_terminal_reached};          // RULE6

  assign lane0_disparity_over_limit    = l0_bde_cnt >= error_threshold_q;     // RULE7 RULE10
  assign lane0_invalid_code_over_limit = l0_nit_cnt >= error_threshold_q;     // RULE8 RULE10
  assign lane0_control_char_over_limit = l0_uek_cnt >= error_threshold_q;     // RULE9 RULE10

  // Sync status bits of this register live elsewhere and read zero here
  always_comb begin
    lane0_link_report = 8'h00;
    lane0_link_report[slem_pkg::POS_OVER_BDE] = lane0_disparity_over_limit;   // RULE7
    lane0_link_report[slem_pkg::POS_OVER_NIT] = lane0_invalid_code_over_limit; // RULE8
    lane0_link_report[slem_pkg::POS_OVER_UEK] = lane0_control_char_over_limit; // RULE9
  end

  logic [31:0] rd_mux;
  assign rd_mux = hit_page ? 32'(link_page_q) :
                  hit_hold ? 32'(hold_at_terminal_q) :
                  hit_thr  ? 32'(error_threshold_q) :
                  hit_l6   ? 32'(lane6_view) :
                  hit_l7   ? 32'(lane7_view) :
                  hit_l0   ? 32'(lane0_link_report) : 32'h0000_0000;

  // Control registers
  // Whole word compared: a sliced compare aliases 2 onto page 0,
  // and a sized link count wraps to zero and locks the page
  logic page_ok;
  assign page_ok = pwdata < 32'(NUM_LINKS);                                  // RULE5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_page_q <= PW'(slem_pkg::RST_PAGE);
    end else if (wr_en && hit_page && page_ok) begin
      link_page_q <= pwdata[PW-1:0];                                         // RULE5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_at_terminal_q <= slem_pkg::RST_HOLD;
    end else if (wr_en && hit_hold) begin
      hold_at_terminal_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_threshold_q <= slem_pkg::RST_THRESH;
    end else if (wr_en && hit_thr) begin
      error_threshold_q <= pwdata[7:0];
    end
  end

  // Read data sampled in setup so that zero-wait access returns it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_cap) begin
      prdata_q <= rd_mux;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_l7;
  logic rd_l6;
  logic rd_l0;
  assign rd_l7 = rd_cap && hit_l7;
  assign rd_l6 = rd_cap && hit_l6;
  assign rd_l0 = rd_cap && hit_l0;

  a_l7_tc_read: assert property (rd_l7 |=> prdata[2:0] == $past(tc_page[23:21]))  // RULE4
    else $error("lane 7 terminal field mismatch");
  a_l6_page_view: assert property (rd_l6 |=>
      prdata[2:0] == $past(tc_flat[link_page_q*NUM_LANES*3 + 18 +: 3]))  // RULE5
    else $error("lane 6 field not from selected link");
  a_l7_enable: assert property (rd_l7 |=>
      prdata[3] == $past(lane_enable[link_page_q*NUM_LANES + 7]) && prdata[7:4] == 4'h0)  // RULE6
    else $error("lane 7 enable bit mismatch");
  a_l0_bde_thr: assert property (rd_l0 |=> prdata[7] == ($past(l0_bde_cnt) >= $past(error_threshold_q)))  // RULE7
    else $error("disparity threshold bit wrong");
  a_l0_nit_thr: assert property (rd_l0 |=> prdata[6] == ($past(l0_nit_cnt) >= $past(error_threshold_q)))  // RULE8
    else $error("table threshold bit wrong");
  a_l0_uek_thr: assert property (rd_l0 |=> prdata[5] == ($past(l0_uek_cnt) >= $past(error_threshold_q)))  // RULE9
    else $error("control char threshold bit wrong");
  a_thr_below: assert property (l0_bde_cnt < error_threshold_q |-> !lane0_link_report[7])  // RULE10
    else $error("threshold bit set below threshold");
  a_bad_addr_err: assert property (access_ph && !addr_hit |-> pslverr && pready)
    else $error("unmapped access not flagged");

  // Bus responses
  a_ro_write_err: assert property (access_ph && pwrite && (hit_l6 || hit_l7 || hit_l0) |->
      pslverr && pready)
    else $error("write to status register not flagged");
  a_no_stray_err: assert property (!access_ph |-> !pslverr)
    else $error("error response outside access phase");
  a_good_wr_ok: assert property (access_ph && pwrite &&
      (hit_page || hit_hold || hit_clr || hit_thr) |-> !pslverr)
    else $error("control write flagged as error");
  a_unmapped_zero: assert property (rd_cap && !addr_hit |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_clr_reads_zero: assert property (rd_cap && hit_clr |=> prdata == 32'h0000_0000)
    else $error("clear register read nonzero");
  a_rd_data_hold: assert property (!rd_cap |=> $stable(prdata))
    else $error("read data moved without a read");

  // Control registers
  a_page_take: assert property (wr_en && hit_page && pwdata < 32'(NUM_LINKS) |=>  // RULE5
      32'(link_page_q) == $past(pwdata))
    else $error("valid page write not taken");
  a_page_refuse: assert property (wr_en && hit_page && pwdata >= 32'(NUM_LINKS) |=>  // RULE5
      $stable(link_page_q))
    else $error("out-of-range page accepted");
  a_page_steady: assert property (!(wr_en && hit_page) |=> $stable(link_page_q))  // RULE5
    else $error("page moved without a write");
  a_hold_read: assert property (rd_cap && hit_hold |=>
      prdata == 32'($past(hold_at_terminal_q)))
    else $error("hold register read mismatch");
  a_thr_read: assert property (rd_cap && hit_thr |=>
      prdata == 32'($past(error_threshold_q)))
    else $error("threshold register read mismatch");

  // Status views
  a_l6_enable: assert property (rd_l6 |=>
      prdata[3] == $past(lane_enable[link_page_q*NUM_LANES + 6]) && prdata[31:4] == 28'h0)
    else $error("lane 6 enable bit mismatch");
  a_l0_sync_zero: assert property (rd_l0 |=> prdata[4:0] == 5'h00 && prdata[31:8] == 24'h0)
    else $error("lane 0 report reserved bits set");

  // Threshold compares; a full counter is at or above any threshold
  a_thr_nit_below: assert property (                                          // RULE10
      l0_nit_cnt < error_threshold_q |-> !lane0_link_report[6])
    else $error("table threshold bit set below threshold");
  a_thr_uek_below: assert property (                                          // RULE10
      l0_uek_cnt < error_threshold_q |-> !lane0_link_report[5])
    else $error("control char threshold bit set below threshold");
  a_thr_bde_max: assert property (l0_bde_cnt == slem_pkg::TERMINAL_CNT |->  // RULE7 RULE10
      lane0_link_report[7])
    else $error("full disparity counter not reported");
  a_thr_nit_max: assert property (l0_nit_cnt == slem_pkg::TERMINAL_CNT |->  // RULE8 RULE10
      lane0_link_report[6])
    else $error("full table counter not reported");
  a_thr_uek_max: assert property (l0_uek_cnt == slem_pkg::TERMINAL_CNT |->  // RULE9 RULE10
      lane0_link_report[5])
    else $error("full control char counter not reported");

  // Clear of the paged link; an event in the same cycle leaves one
  a_l0_clr_bde: assert property (wr_en && hit_clr && pwdata[slem_pkg::POS_TC_BDE] |=>  // RULE11
      l0_bde_cnt <= 8'h01)
    else $error("lane 0 disparity counter not cleared");
  a_l0_clr_nit: assert property (wr_en && hit_clr && pwdata[slem_pkg::POS_TC_NIT] |=>  // RULE11
      l0_nit_cnt <= 8'h01)
    else $error("lane 0 table counter not cleared");
  a_l0_clr_uek: assert property (wr_en && hit_clr && pwdata[slem_pkg::POS_TC_UEK] |=>  // RULE11
      l0_uek_cnt <= 8'h01)
    else $error("lane 0 control char counter not cleared");

  c_l7_terminal: cover property (rd_l7 ##1 prdata[2]);
  c_page_switch: cover property (wr_en && hit_page ##1 link_page_q != $past(link_page_q));
  c_thr_reached: cover property (rd_l0 ##1 prdata[7]);
  c_counter_clr: cover property (wr_en && hit_clr);
  c_ro_write: cover property (access_ph && pwrite && hit_l7 && pslverr);

endmodule : slem_monitor
`default_nettype wire

// [testbench/slem_lane_src.sv]
/*
  Lane decoder stand-in: repeats a pattern of decode error pulses num times.
  Assumes go is a one-cycle request from the bench, synchronous to pclk.
*/
`default_nettype none
module slem_lane_src (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request from the bench
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [47:0] pat,
  input  wire logic [15:0] num,
  // Lane side
  output var slem_pkg::slem_lane_err_s [15:0] lane_err,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left_q;
  logic        gap_q;
  // Busy covers the last pulse too, so a read after it sees the final count
  assign busy = (left_q != 16'h0000) || (lane_err != '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q   <= 16'h0000;
      gap_q    <= 1'b0;
      lane_err <= '0;
    end else begin
      gap_q <= ~gap_q;
      if (go) begin
        left_q   <= num;
        lane_err <= '0;
      end else if (left_q != 16'h0000 && !(slow && gap_q)) begin
        left_q   <= left_q - 16'h0001;
        lane_err <= pat;
      end else begin
        lane_err <= '0;
      end
    end
  end
endmodule // slem_lane_src
`default_nettype wire

// [testbench/tb.sv]
/*
  Self-checking bench for the lane error monitor, registers over APB.
  Assumes an APB slave of any latency and slem_lane_src as the error source.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, go, slow, busy, er;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [47:0] pat;
  logic [15:0] num, lane_enable;
  slem_pkg::slem_lane_err_s [15:0] lane_err;
  int          err_total, compares, seed, t, thr, lk;
  int          cyc = 0;

  slem_monitor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lane_err(lane_err), .lane_enable(lane_enable));
  slem_lane_src i_src (.pclk(pclk), .presetn(presetn), .go(go), .slow(slow), .pat(pat),
    .num(num), .lane_err(lane_err), .busy(busy));

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx[10:0], 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the cycle ceiling ends a stalled access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    er  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp, input string nm);
    apb(1'b0, idx, 32'h0000_0000);
    chk(nm, exp, rdv);
    chk("rd_err", 32'h0, {31'h0, er});
  endtask

  task automatic send(input logic [47:0] p, input int n);
    @(posedge pclk);
    pat  <= p;
    num  <= 16'(n);
    slow <= 1'($random(seed));
    go   <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy !== 1'b0) begin
      @(posedge pclk);
    end
  endtask

  // Threshold bit of lane 0 for error type t
  function automatic logic [31:0] lbit(input int ty);
    return 32'h80 >> ty;
  endfunction

  initial begin
    seed = 18959;
    {presetn, psel, penable, pwrite, go, slow} = '0;
    {paddr, pwdata, pat, num} = '0;
    lane_enable = 16'($random(seed));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h300, 32'h0, "page");
    rdc(12'h482, 32'hFF, "thresh");
    rdc(12'h4B0, 32'h0, "link0");
    apb(1'b0, 12'h123, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b1, 12'h497, 32'hF);
    chk("ro_err", 32'h1, {31'h0, er});
    for (lk = 0; lk < 2; lk++) begin
      apb(1'b1, 12'h300, 32'(lk));
      rdc(12'h496, {28'h0, lane_enable[lk*8+6], 3'h0}, "lane6");
      rdc(12'h497, {28'h0, lane_enable[lk*8+7], 3'h0}, "lane7");
    end
    // Lane 0 all types, lane 6 control char only, lane 7 table only
    apb(1'b1, 12'h300, 32'h0);
    apb(1'b1, 12'h480, 32'h5);
    send(48'h500007, 254);
    rdc(12'h497, {28'h0, lane_enable[7], 3'h0}, "tc254");
    send(48'h500007, 1);
    rdc(12'h496, {28'h0, lane_enable[6], 3'h4}, "tc6");
    rdc(12'h4B0, 32'hE0, "link255");
    send(48'h500007, 1);
    rdc(12'h4B0, 32'hA0, "link256");
    rdc(12'h497, {28'h0, lane_enable[7], 3'h2}, "tc7");
    apb(1'b1, 12'h300, 32'h1);
    rdc(12'h497, {28'h0, lane_enable[15], 3'h0}, "tc_page1");
    apb(1'b1, 12'h300, 32'h0);
    apb(1'b1, 12'h481, 32'h7);
    rdc(12'h496, {28'h0, lane_enable[6], 3'h0}, "tc_clear");
    for (t = 0; t < 3; t++) begin
      lk  = {$random(seed)} % 2;
      thr = 1 + {$random(seed)} % 40;
      // Other link starts clean, so its view must stay zero below
      apb(1'b1, 12'h300, 32'(1 - lk));
      apb(1'b1, 12'h481, 32'h7);
      apb(1'b1, 12'h300, 32'(lk));
      apb(1'b1, 12'h300, 32'h2);
      rdc(12'h300, 32'(lk), "page_keep");
      apb(1'b1, 12'h481, 32'h7);
      apb(1'b1, 12'h482, 32'(thr));
      send(48'h1 << (lk * 24 + t), thr - 1);
      rdc(12'h4B0, 32'h0, "below");
      send(48'h1 << (lk * 24 + t), 1);
      rdc(12'h4B0, lbit(t), "reached");
      apb(1'b1, 12'h300, 32'(1 - lk));
      rdc(12'h4B0, 32'h0, "other_page");
      apb(1'b1, 12'h481, 32'h7);
    end
    results();
  end
endmodule // tb
`default_nettype wire
